// ### src/fev_cfg.svh
// offsets, field positions, reset values and widths of the event registers
`ifndef FEV_CFG_SVH
`define FEV_CFG_SVH

`define FEV_ADDR_W        16
`define FEV_DATA_W        32
`define FEV_OFS_FLAGS     16'h0130
`define FEV_OFS_ENABLE    16'h0134
`define FEV_OFS_STATE     16'h0138
`define FEV_OFS_TRIGGER   16'h013c
`define FEV_INTR_BIT      15
`define FEV_WAKE_BIT      4
`define FEV_BVD_HI        3
`define FEV_BVD_LO        2
`define FEV_READY_BIT     1
`define FEV_WP_BIT        0
`define FEV_BVD_VAL       2'h3
`define FEV_FLAG_RST      1'h0
`define FEV_MASK_RST      1'h0
`define FEV_SYNC_STAGES   3

`endif

// ### src/fev_pkg.sv
// types shared by the function event register block
`include "fev_cfg.svh"

package fev_pkg;

    typedef struct packed
    {
        logic                    wr;
        logic                    rd;
        logic [`FEV_ADDR_W-1:0]  addr;
        logic [`FEV_DATA_W-1:0]  wdata;
    } fev_req_t;

    typedef struct packed
    {
        logic                    valid;
        logic [`FEV_DATA_W-1:0]  data;
    } fev_rsp_t;

endpackage

// ### src/fev_src_sync.sv
// three-stage synchroniser for an interrupt level from another clock
`timescale 1ns/1ps
`include "fev_cfg.svh"

module fev_src_sync
#(
    parameter int STAGES = `FEV_SYNC_STAGES
)
(
    input  wire logic  ref_clk,
    input  wire logic  rst,
    input  wire logic  level_in,
    output logic       level_out
);
    import fev_pkg::*;

    logic [STAGES-1:0] stage_reg;
    logic              level_reg;

    // ****************************************************************
    // parameter check
    // ****************************************************************
    if (STAGES != 3)
    begin : g_bad
        $error("fev_src_sync: STAGES must be 3");
    end

    // ****************************************************************
    // shift chain
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            stage_reg <= '0;
        else
            stage_reg <= {stage_reg[STAGES-2:0], level_in};
    end

    // change accepted once second and third stages agree
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            level_reg <= 1'h0;
        else if (stage_reg[1] == stage_reg[2])
            level_reg <= stage_reg[2];
    end

    assign level_out = level_reg;

endmodule

// ### src/fev_regs.sv
// function event, enable, current state and trigger registers
`timescale 1ns/1ps
`include "fev_cfg.svh"

module fev_regs
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire fev_pkg::fev_req_t req,
    output fev_pkg::fev_rsp_t      rsp,
    input  wire logic       chip_irq_src,
    output logic            status_irq
);
    import fev_pkg::*;

    logic                    flag_reg;
    logic                    mask_reg;
    logic                    src_sync;
    logic                    rvalid_reg;
    logic [`FEV_DATA_W-1:0]  rdata_reg;
    logic [`FEV_DATA_W-1:0]  rdata_next;
    logic [`FEV_DATA_W-1:0]  state_word;
    logic [`FEV_DATA_W-1:0]  flag_word;
    logic [`FEV_DATA_W-1:0]  mask_word;
    logic                    wr_flags;
    logic                    wr_enable;
    logic                    wr_trigger;
    logic                    set_evt;
    logic                    clr_evt;

    // ****************************************************************
    // configuration check
    // ****************************************************************
    if (`FEV_INTR_BIT >= `FEV_DATA_W)
    begin : g_bad_cfg
        $error("fev_regs: interrupt bit outside the data word");
    end

    // ****************************************************************
    // address decode
    // ****************************************************************
    assign wr_flags   = req.wr && (req.addr == `FEV_OFS_FLAGS);
    assign wr_enable  = req.wr && (req.addr == `FEV_OFS_ENABLE);
    assign wr_trigger = req.wr && (req.addr == `FEV_OFS_TRIGGER);

    // ****************************************************************
    // event flag
    // ****************************************************************
    assign set_evt = wr_trigger && req.wdata[`FEV_INTR_BIT];
    assign clr_evt = wr_flags && req.wdata[`FEV_INTR_BIT];

    // set wins over a clear in the same cycle
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            flag_reg <= `FEV_FLAG_RST;
        else if (set_evt)
            flag_reg <= 1'h1;
        else if (clr_evt)
            flag_reg <= 1'h0;
    end

    // ****************************************************************
    // event enable
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            mask_reg <= `FEV_MASK_RST;
        else if (wr_enable)
            mask_reg <= req.wdata[`FEV_INTR_BIT];
    end

    assign status_irq = flag_reg && mask_reg;

    // ****************************************************************
    // chip interrupt sources
    // ****************************************************************
    fev_src_sync
    #(
        .STAGES    (`FEV_SYNC_STAGES)
    )
    u_src_sync
    (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .level_in  (chip_irq_src),
        .level_out (src_sync)
    );

    // ****************************************************************
    // read words
    // ****************************************************************
    always_comb
    begin
        flag_word = '0;
        flag_word[`FEV_INTR_BIT] = flag_reg;
        mask_word = '0;
        mask_word[`FEV_INTR_BIT] = mask_reg;
        state_word = '0;
        state_word[`FEV_INTR_BIT] = src_sync;
        state_word[`FEV_WAKE_BIT] = 1'h0;
        state_word[`FEV_BVD_HI:`FEV_BVD_LO] = `FEV_BVD_VAL;
        state_word[`FEV_READY_BIT] = 1'h1;
        state_word[`FEV_WP_BIT] = 1'h0;
    end

    // unmapped offsets and the trigger register read zero
    always_comb
    begin
        if (req.addr == `FEV_OFS_FLAGS)
            rdata_next = flag_word;
        else if (req.addr == `FEV_OFS_ENABLE)
            rdata_next = mask_word;
        else if (req.addr == `FEV_OFS_STATE)
            rdata_next = state_word;
        else
            rdata_next = '0;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rdata_reg <= '0;
        else if (req.rd)
            rdata_reg <= rdata_next;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rvalid_reg <= 1'h0;
        else
            rvalid_reg <= req.rd;
    end

    assign rsp.valid = rvalid_reg;
    assign rsp.data  = rdata_reg;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    force_sets_flag_a: assert property (set_evt |=> flag_reg [*1])
        else $error("trigger write did not set event flag");

    irq_follows_flag_a: assert property (
        (set_evt && mask_reg) |=> status_irq)
        else $error("unmasked trigger did not raise status interrupt");

    irq_clear_a: assert property (
        (clr_evt && !set_evt) |=> !status_irq)
        else $error("status interrupt stayed after flag clear");

    irq_mask_drop_a: assert property (
        (wr_enable && !req.wdata[`FEV_INTR_BIT]) |=> !status_irq)
        else $error("status interrupt stayed after mask clear");

    one_clears_flag_a: assert property (
        (clr_evt && !set_evt) |=> !flag_reg)
        else $error("write one did not clear event flag");

    zero_keeps_flag_a: assert property (
        (wr_flags && !req.wdata[`FEV_INTR_BIT] && !set_evt)
        |=> $stable(flag_reg))
        else $error("write zero changed event flag");

    flag_hold_a: assert property (
        (!set_evt && !clr_evt) |=> $stable(flag_reg))
        else $error("event flag changed without a write");

    force_no_clear_a: assert property (
        (wr_trigger && !req.wdata[`FEV_INTR_BIT]) |=> $stable(flag_reg))
        else $error("trigger write of zero changed event flag");

    mask_hold_a: assert property (
        !wr_enable |=> $stable(mask_reg))
        else $error("enable bit changed without a write");

    flag_read_a: assert property (
        (req.rd && req.addr == `FEV_OFS_FLAGS)
        |=> rsp.valid && rsp.data == {16'h0000, $past(flag_reg), 15'h0000})
        else $error("event register read wrong");

    mask_write_a: assert property (
        wr_enable |=> mask_reg == $past(req.wdata[`FEV_INTR_BIT]))
        else $error("enable bit not stored");

    mask_read_a: assert property (
        (req.rd && req.addr == `FEV_OFS_ENABLE)
        |=> rsp.data == {16'h0000, $past(mask_reg), 15'h0000})
        else $error("enable register read wrong");

    state_src_a: assert property (
        (req.rd && req.addr == `FEV_OFS_STATE)
        |=> rsp.data[`FEV_INTR_BIT] == $past(src_sync))
        else $error("state interrupt bit wrong");

    state_fixed_a: assert property (
        (req.rd && req.addr == `FEV_OFS_STATE)
        |=> rsp.data[4:0] == 5'h0e && rsp.data[31:16] == 16'h0000)
        else $error("state fixed fields wrong");

    state_reserved_a: assert property (
        (req.rd && req.addr == `FEV_OFS_STATE)
        |=> rsp.data[14:5] == 10'h000)
        else $error("state reserved bits not zero");

    trigger_read_a: assert property (
        (req.rd && req.addr == `FEV_OFS_TRIGGER) |=> rsp.data == 32'h0)
        else $error("trigger register read not zero");

    valid_pulse_a: assert property (!req.rd |=> !rsp.valid)
        else $error("read answer without request");

    valid_follows_a: assert property (
        req.rd |=> rsp.valid)
        else $error("read request without answer");

    data_hold_a: assert property (
        !req.rd |=> $stable(rsp.data))
        else $error("read data changed without a read");

    forced_irq_c: cover property (set_evt && mask_reg ##1 status_irq);
    cleared_irq_c: cover property (status_irq ##1 clr_evt ##1 !status_irq);
    masked_force_c: cover property (set_evt && !mask_reg ##1 !status_irq);
    state_read_c: cover property (src_sync && req.rd
        && req.addr == `FEV_OFS_STATE);

endmodule

// ### testbench/fev_regs_tb_top.sv
// self-checking testbench for the function event registers
`timescale 1ns/1ps
`include "fev_cfg.svh"

module fev_regs_tb_top;
    import fev_pkg::*;

    logic      ref_clk;
    logic      rst;
    fev_req_t  req;
    fev_rsp_t  rsp;
    logic      chip_irq_src;
    logic      status_irq;
    int        bad_count;
    int        checked;

    fev_regs dut
    (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .req          (req),
        .rsp          (rsp),
        .chip_irq_src (chip_irq_src),
        .status_irq   (status_irq)
    );

    // ********************************
    // clock, compare and access tasks
    // ********************************
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] addr, input logic [31:0] data);
        req.wr    = 1'b1;
        req.addr  = addr;
        req.wdata = data;
        @(negedge ref_clk);
        req.wr    = 1'b0;
        req.wdata = ~data;
        @(negedge ref_clk);
    endtask

    task automatic rd(input logic [15:0] addr, input logic [31:0] exp);
        req.rd   = 1'b1;
        req.addr = addr;
        @(negedge ref_clk);
        req.rd   = 1'b0;
        check({31'h0, rsp.valid}, 32'h1);
        check(rsp.data, exp);
        @(negedge ref_clk);
    endtask

    task automatic irq(input logic exp);
        check({31'h0, status_irq}, {31'h0, exp});
    endtask

    task automatic end_of_test;
        if (bad_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ********************************
    // watchdog
    // ********************************
    initial
    begin
        #20000;
        bad_count++;
        end_of_test();
    end

    // ********************************
    // test sequence
    // ********************************
    initial
    begin
        rst          = 1'b1;
        req          = '0;
        chip_irq_src = 1'b0;
        bad_count    = 0;
        checked      = 0;
        repeat (5) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        rd(`FEV_OFS_FLAGS, 32'h0);
        rd(`FEV_OFS_ENABLE, 32'h0);
        rd(`FEV_OFS_STATE, 32'h0000000e);
        rd(`FEV_OFS_TRIGGER, 32'h0);
        rd(16'h0140, 32'h0);
        // writes of ones to the flag word never set it
        wr(`FEV_OFS_FLAGS, 32'hffffffff);
        rd(`FEV_OFS_FLAGS, 32'h0);
        // trigger with bit 15 low does nothing
        wr(`FEV_OFS_TRIGGER, 32'hffff7fff);
        rd(`FEV_OFS_FLAGS, 32'h0);
        irq(1'b0);
        // trigger sets the flag; mask still clear
        wr(`FEV_OFS_TRIGGER, 32'hffffffff);
        irq(1'b0);
        rd(`FEV_OFS_FLAGS, 32'h00008000);
        rd(`FEV_OFS_TRIGGER, 32'h0);
        rd(`FEV_OFS_STATE, 32'h0000000e);
        // enabling the mask raises the interrupt
        wr(`FEV_OFS_ENABLE, 32'hffffffff);
        rd(`FEV_OFS_ENABLE, 32'h00008000);
        irq(1'b1);
        // zeros at bit 15 leave the flag set
        wr(`FEV_OFS_FLAGS, 32'hffff7fff);
        rd(`FEV_OFS_FLAGS, 32'h00008000);
        irq(1'b1);
        // clear through the flag word
        wr(`FEV_OFS_FLAGS, 32'h00008000);
        rd(`FEV_OFS_FLAGS, 32'h0);
        irq(1'b0);
        // masked trigger stays quiet
        wr(`FEV_OFS_ENABLE, 32'h0);
        wr(`FEV_OFS_TRIGGER, 32'h00008000);
        irq(1'b0);
        rd(`FEV_OFS_ENABLE, 32'h0);
        wr(`FEV_OFS_ENABLE, 32'h00008000);
        irq(1'b1);
        wr(`FEV_OFS_FLAGS, 32'h00008000);
        irq(1'b0);
        // other chip sources appear in the state word
        chip_irq_src = 1'b1;
        repeat (6) @(negedge ref_clk);
        rd(`FEV_OFS_STATE, 32'h0000800e);
        irq(1'b0);
        chip_irq_src = 1'b0;
        repeat (6) @(negedge ref_clk);
        rd(`FEV_OFS_STATE, 32'h0000000e);
        // reset in mid-run clears flag and mask
        wr(`FEV_OFS_TRIGGER, 32'h00008000);
        irq(1'b1);
        rst = 1'b1;
        @(negedge ref_clk);
        rst = 1'b0;
        irq(1'b0);
        @(negedge ref_clk);
        rd(`FEV_OFS_FLAGS, 32'h0);
        rd(`FEV_OFS_ENABLE, 32'h0);
        end_of_test();
    end
endmodule
